// >>> inc/asq_map.svh
`ifndef ASQ_MAP_SVH
`define ASQ_MAP_SVH
// register byte offsets
`define ASQ_CTRL_OFS      12'h000
`define ASQ_CSR_OFS       12'h004
`define ASQ_RES_OFS       12'h020
// conversion_control fields
`define ASQ_TRG_HI_POS    7
`define ASQ_TRG_MID_POS   6
`define ASQ_SCAN_EN_POS   5
`define ASQ_SCAN_SZ_POS   4
`define ASQ_CKS_HI_POS    3
`define ASQ_CKS_LO_POS    2
`define ASQ_AUTO_CLR_POS  1
`define ASQ_TRG_EXT_POS   0
// control_status_reg fields
`define ASQ_END_FLAG_POS  7
`define ASQ_IRQ_EN_POS    6
`define ASQ_START_POS     5
`define ASQ_CTRL_RST      8'h00
`define ASQ_CSR_RST       8'h00
// conversion lengths in peripheral states, first and later
`define ASQ_FIRST_00      9'd46
`define ASQ_FIRST_01      9'd87
`define ASQ_FIRST_10      9'd168
`define ASQ_FIRST_11      9'd332
`define ASQ_NEXT_00       9'd40
`define ASQ_NEXT_01       9'd80
`define ASQ_NEXT_10       9'd160
`define ASQ_NEXT_11       9'd320
`endif

// >>> inc/asq_pkg.sv
package asq_pkg;
    // converter states, gray along idle-convert-store
    typedef enum logic [1:0]
    {
        ASQ_IDLE    = 2'b00,
        ASQ_CONVERT = 2'b01,
        ASQ_STORE   = 2'b11
    } asq_state_e;
    // trigger source encodings
    typedef logic [2:0] asq_trg_t;
    localparam asq_trg_t ASQ_TRG_SW    = 3'h0;
    localparam asq_trg_t ASQ_TRG_PULSE = 3'h2;
    localparam asq_trg_t ASQ_TRG_TIMER = 3'h4;
    localparam asq_trg_t ASQ_TRG_PIN   = 3'h6;
endpackage : asq_pkg

// >>> rtl/asq_ctrl.sv
`timescale 1ns/10ps
`include "asq_map.svh"

// What this block does
// - trigger code 000 ignores all hardware triggers, software start only.
// - code 010 lets the pulse unit trigger set the start bit.
// - code 100 lets the timer unit trigger set the start bit.
// - code 110 accepts the external trigger pin as start source.
// - code 001 disables every external trigger input.
// - scan enable low means single mode whatever scan size says.
// - mode 10 scan_size up to four channels, mode 11 up to eight.
// - clock select divides peripheral clock by 2, 2, 4 or 8.
// - first conversion lasts 46, 87, 168 or 332 states.
// - auto stop clear one clears start after full scan, else never.
// - single mode converts selected channel once and stores its result.
// - end flag sets at single end or scan pass end; irq if enabled.
// - single start stays one, self-clears at end; clearing aborts.
// - four-channel scan starts at 0 or 4; eight-channel at 0.
// - scan converts channels in turn, storing each result at once.
// - continuous scan restarts from first channel after each pass.
// - continuous start never self-clears; clear stops, set restarts.
// - one-cycle scan clears start after one pass and waits.
// - successive approximation gives a 10-bit result per conversion.
// - selected pin trigger sets start on falling edge, like software.
// - later scan conversions take fixed 40, 80, 160 or 320 states.
// - end flag clears by zero write after reading one, or DMA read.
module asq_ctrl
#(
    parameter int RES_W = 10,
    parameter int NCH   = 8
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              pulse_unit_trig,
    input  wire logic              timer_unit_trig,
    input  wire logic              external_trigger_pin_n,
    input  wire logic              dma_result_read,
    input  wire logic              comparator_hi,
    output logic      [2:0]        sample_channel,
    output logic                   conversion_clock,
    output logic                   conversion_end_irq
);

    // sar, result store and channel count are fixed; refuse other sizes
    if (RES_W != 10 || NCH != 8)
    begin : g_bad_size
        $error("asq_ctrl: only 10-bit results over 8 channels");
    end

    // =========================================================
    // registers
    // =========================================================
    logic [7:0]       conversion_control;
    logic             conversion_end_flag;
    logic             end_irq_enable;
    logic             conversion_start_bit;
    logic [3:0]       channel_select;
    logic             flag_seen_one;
    logic [RES_W-1:0] result_mem [NCH];
    asq_pkg::asq_state_e state;

    logic [2:0] trg_sel;
    logic       scan_enable;
    logic       scan_size;
    logic [1:0] conv_clock_sel;
    logic       auto_stop_clear;
    assign trg_sel = {conversion_control[`ASQ_TRG_HI_POS],
                      conversion_control[`ASQ_TRG_MID_POS],
                      conversion_control[`ASQ_TRG_EXT_POS]};
    assign scan_enable     = conversion_control[`ASQ_SCAN_EN_POS];
    assign scan_size       = conversion_control[`ASQ_SCAN_SZ_POS];
    assign conv_clock_sel  = {conversion_control[`ASQ_CKS_HI_POS],
                              conversion_control[`ASQ_CKS_LO_POS]};
    assign auto_stop_clear = conversion_control[`ASQ_AUTO_CLR_POS];

    // =========================================================
    // bus decode
    // =========================================================
    logic wr_en;
    logic rd_en;
    logic hit_ctrl;
    logic hit_csr;
    logic hit_res;
    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && penable && !pwrite;
    assign hit_ctrl = paddr == `ASQ_CTRL_OFS;
    assign hit_csr  = paddr == `ASQ_CSR_OFS;
    assign hit_res  = paddr[11:5] == 7'(`ASQ_RES_OFS >> 5) &&
                      paddr[1:0] == 2'b00;

    // =========================================================
    // input synchronisers and trigger edges
    // =========================================================
    logic [1:0] pin_sync;
    logic [1:0] pulse_sync;
    logic [1:0] timer_sync;
    logic       pin_last;
    logic       pulse_last;
    logic       timer_last;
    // two flops per asynchronous source; edges read only the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_sync   <= 2'b11;
            pulse_sync <= 2'b00;
            timer_sync <= 2'b00;
            pin_last   <= 1'b1;
            pulse_last <= 1'b0;
            timer_last <= 1'b0;
        end
        else
        begin
            pin_sync   <= {pin_sync[0], external_trigger_pin_n};
            pulse_sync <= {pulse_sync[0], pulse_unit_trig};
            timer_sync <= {timer_sync[0], timer_unit_trig};
            pin_last   <= pin_sync[1];
            pulse_last <= pulse_sync[1];
            timer_last <= timer_sync[1];
        end
    end

    logic hw_trigger;
    // only the three legal source codes pass a trigger through
    always_comb
    begin
        case (trg_sel)
            asq_pkg::ASQ_TRG_PULSE: hw_trigger = pulse_sync[1] && !pulse_last;
            asq_pkg::ASQ_TRG_TIMER: hw_trigger = timer_sync[1] && !timer_last;
            asq_pkg::ASQ_TRG_PIN:   hw_trigger = !pin_sync[1] && pin_last;
            default: hw_trigger = 1'b0;
        endcase
    end

    // =========================================================
    // conversion clock divider and timing
    // =========================================================
    logic [2:0] div_cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt <= 3'h0;
        else
            div_cnt <= div_cnt + 3'h1;
    end

    // divided clock; code 00 toggles each edge, as a flop cannot run at pclk
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            conversion_clock <= 1'b0;
        else
        begin
            case (conv_clock_sel)
                2'b00:   conversion_clock <= !conversion_clock;
                2'b01:   conversion_clock <= div_cnt[0];
                2'b10:   conversion_clock <= div_cnt[1];
                default: conversion_clock <= div_cnt[2];
            endcase
        end
    end

    logic [8:0] conv_len;
    logic       first_conv;
    // first conversion carries start delay; later scan ones are fixed
    always_comb
    begin
        case (conv_clock_sel)
            2'b00:   conv_len = first_conv ? `ASQ_FIRST_00 : `ASQ_NEXT_00;
            2'b01:   conv_len = first_conv ? `ASQ_FIRST_01 : `ASQ_NEXT_01;
            2'b10:   conv_len = first_conv ? `ASQ_FIRST_10 : `ASQ_NEXT_10;
            default: conv_len = first_conv ? `ASQ_FIRST_11 : `ASQ_NEXT_11;
        endcase
    end

    // =========================================================
    // channel group
    // =========================================================
    logic [2:0] first_ch;
    logic [2:0] last_ch;
    always_comb
    begin
        if (!scan_enable)
        begin
            first_ch = channel_select[2:0];
            last_ch  = channel_select[2:0];
        end
        else if (!scan_size)
        begin
            first_ch = {channel_select[2], 2'b00};
            last_ch  = channel_select[2:0];
        end
        else
        begin
            first_ch = 3'h0;
            last_ch  = channel_select[2:0];
        end
    end

    // =========================================================
    // sequencer: timing plus successive approximation
    // =========================================================
    logic [8:0]       cyc_cnt;
    logic [RES_W-1:0] sar;
    logic [3:0]       bit_idx;
    logic             pass_done;
    logic             start_set;
    assign start_set = hw_trigger ||
        (wr_en && hit_csr && pwdata[`ASQ_START_POS]);
    assign pass_done = state == asq_pkg::ASQ_STORE &&
        sample_channel == last_ch;

    // one sar bit per step, decided over the first RES_W cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state          <= asq_pkg::ASQ_IDLE;
            cyc_cnt        <= 9'h000;
            sar            <= '0;
            bit_idx        <= 4'h0;
            sample_channel <= 3'h0;
            first_conv     <= 1'b1;
        end
        else if (!conversion_start_bit)
            state <= asq_pkg::ASQ_IDLE;
        else
        begin
            case (state)
                asq_pkg::ASQ_IDLE:
                begin
                    state          <= asq_pkg::ASQ_CONVERT;
                    sample_channel <= first_ch;
                    first_conv     <= 1'b1;
                    cyc_cnt        <= 9'h001;
                    sar            <= 10'h200;
                    bit_idx        <= 4'h9;
                end
                asq_pkg::ASQ_CONVERT:
                begin
                    cyc_cnt <= cyc_cnt + 9'h001;
                    if (bit_idx != 4'hF)
                    begin
                        // keep or drop trial bit, then try the next
                        if (!comparator_hi)
                            sar[bit_idx] <= 1'b0;
                        if (bit_idx != 4'h0)
                            sar[bit_idx - 4'h1] <= 1'b1;
                        bit_idx <= bit_idx - 4'h1;
                    end
                    if (cyc_cnt >= conv_len - 9'h001)
                        state <= asq_pkg::ASQ_STORE;
                end
                asq_pkg::ASQ_STORE:
                begin
                    // next channel, or wrap to the group start
                    state      <= asq_pkg::ASQ_CONVERT;
                    first_conv <= 1'b0;
                    cyc_cnt    <= 9'h001;
                    sar        <= 10'h200;
                    bit_idx    <= 4'h9;
                    if (pass_done)
                        sample_channel <= first_ch;
                    else
                        sample_channel <= sample_channel + 3'h1;
                end
                default: state <= asq_pkg::ASQ_IDLE;
            endcase
        end
    end

    // result stored as each channel finishes
    always_ff @(posedge pclk)
    begin
        if (state == asq_pkg::ASQ_STORE && conversion_start_bit)
            result_mem[sample_channel] <= sar;
    end

    // =========================================================
    // control and status registers
    // =========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conversion_control <= `ASQ_CTRL_RST;
            channel_select     <= 4'h0;
            end_irq_enable     <= 1'b0;
        end
        else if (wr_en && hit_ctrl)
            conversion_control <= pwdata[7:0];
        else if (wr_en && hit_csr)
        begin
            channel_select <= pwdata[3:0];
            end_irq_enable <= pwdata[`ASQ_IRQ_EN_POS];
        end
    end

    // start: software write or trigger sets; auto clear per mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            conversion_start_bit <= 1'b0;
        else if (start_set)
            conversion_start_bit <= 1'b1;
        else if (wr_en && hit_csr)
            conversion_start_bit <= 1'b0;
        else if (pass_done && (!scan_enable || auto_stop_clear))
            conversion_start_bit <= 1'b0;
    end

    // end flag: hardware set beats any clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conversion_end_flag <= 1'b0;
            flag_seen_one       <= 1'b0;
        end
        else
        begin
            if (pass_done && conversion_start_bit)
                conversion_end_flag <= 1'b1;
            else if ((wr_en && hit_csr && !pwdata[`ASQ_END_FLAG_POS] &&
                      flag_seen_one) || dma_result_read)
                conversion_end_flag <= 1'b0;
            if (rd_en && hit_csr && conversion_end_flag)
                flag_seen_one <= 1'b1;
            else if (wr_en && hit_csr)
                flag_seen_one <= 1'b0;
        end
    end

    // interrupt line, registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            conversion_end_irq <= 1'b0;
        else
            conversion_end_irq <= conversion_end_flag && end_irq_enable;
    end

    // =========================================================
    // apb answer: zero wait, registered read data
    // =========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            // ready in the first access cycle: no wait state
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(hit_ctrl || hit_csr || hit_res);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                if (hit_ctrl)
                    prdata <= {24'h000000, conversion_control};
                else if (hit_csr)
                    prdata <= {24'h000000, conversion_end_flag,
                               end_irq_enable, conversion_start_bit,
                               1'b0, channel_select};
                else if (hit_res)
                    prdata <= {22'h0, result_mem[paddr[4:2]]};
            end
        end
    end

endmodule : asq_ctrl

// >>> verif/asq_ctrl_props.sv
`timescale 1ns/10ps
`include "asq_map.svh"
// ============================================================
// port-level checker for the converter sequencer
module asq_ctrl_props
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        dma_result_read,
    input wire logic [2:0]  sample_channel,
    input wire logic        conversion_clock,
    input wire logic        conversion_end_irq
);
    logic [7:0] ctl_q;
    logic [7:0] csr_q;
    logic [3:0] age;
    logic [2:0] prv;
    logic [7:0] gap;
    logic       acc;
    logic       wacc;
    logic       ie;
    logic       chg;
    logic [2:0] first;
    // decoded bus events and channel group start
    assign acc   = psel && penable && pready;
    assign wacc  = acc && pwrite;
    assign ie    = csr_q[6];
    assign chg   = sample_channel != prv;
    assign first = ctl_q[4] ? 3'h0 : {csr_q[2], 2'h0};
    // shadow of both control registers; age tells a settled setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_q <= 8'h00;
            csr_q <= 8'h00;
            age   <= 4'h0;
        end
        else
        begin
            if (wacc && paddr == `ASQ_CTRL_OFS)
                ctl_q <= pwdata[7:0];
            if (wacc && paddr == `ASQ_CSR_OFS)
                csr_q <= pwdata[7:0];
            if (wacc && paddr == `ASQ_CTRL_OFS)
                age <= 4'h0;
            else if (age != 4'hF)
                age <= age + 4'h1;
        end
    end
    // cycles since the channel last moved, saturating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prv <= 3'h0;
            gap <= 8'hFF;
        end
        else
        begin
            prv <= sample_channel;
            gap <= chg ? 8'h00 : (gap == 8'hFF ? gap : gap + 8'h01);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_irq_masked: assert property (
        !ie && !$past(ie) |-> !conversion_end_irq)
        else $error("irq while disabled");
    chk_irq_clear_cause: assert property (
        $fell(conversion_end_irq) |-> $past(wacc) || $past(wacc, 2)
        || $past(dma_result_read) || $past(dma_result_read, 2)
        || $past(dma_result_read, 3))
        else $error("irq dropped without cause");
    chk_scan_step: assert property (
        ctl_q[5] && chg |-> sample_channel == prv + 3'h1
        || sample_channel == first)
        else $error("scan order broken");
    chk_scan_range: assert property (
        ctl_q[5] && chg |-> sample_channel >= first
        && sample_channel <= csr_q[2:0])
        else $error("channel outside group");
    chk_scan_gap: assert property (
        ctl_q[5] && ctl_q[3:2] == 2'h0 && age == 4'hF && chg
        |-> gap >= 8'd39)
        else $error("scan conversion too short");
    chk_single_chan: assert property (
        !ctl_q[5] && chg |-> sample_channel == csr_q[2:0])
        else $error("wrong single channel");
    chk_ctrl_read: assert property (
        acc && !pwrite && paddr == `ASQ_CTRL_OFS
        |-> prdata == {24'h000000, ctl_q})
        else $error("control readback wrong");
    chk_clk_div8: assert property (
        age == 4'hF && ctl_q[3:2] == 2'h3 && $changed(conversion_clock)
        |=> $stable(conversion_clock)[*3])
        else $error("divide by eight broken");
    cover property (ctl_q[5] && chg);
    cover property ($rose(conversion_end_irq));
    cover property (acc && pslverr);
endmodule : asq_ctrl_props

// >>> verif/asq_comp_model.sv
`timescale 1ns/10ps
// ============================================================
// comparator stand-in for the analog inputs
module asq_comp_model
(
    input  wire logic [2:0] sample_channel,
    input  wire logic       flip,
    output logic            comparator_hi
);
    // each input sits at full scale or zero, so a result is all ones
    // or all zeros and a mix-up between an odd and an even channel shows at once
    assign comparator_hi = sample_channel[0] ^ flip;
endmodule : asq_comp_model

// >>> verif/adc_sequencer_control_bench.sv
`timescale 1ns/10ps
`include "asq_map.svh"
// ============================================================
// self-checking bench for the converter sequencer
module adc_sequencer_control_bench;
    localparam logic [11:0] CTL = `ASQ_CTRL_OFS;
    localparam logic [11:0] CSR = `ASQ_CSR_OFS;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pulse_unit_trig;
    logic        timer_unit_trig;
    logic        external_trigger_pin_n;
    logic        dma_result_read;
    logic        comparator_hi;
    logic [2:0]  sample_channel;
    logic        conversion_clock;
    logic        conversion_end_irq;
    logic        flip;
    logic [31:0] d;
    logic        e;
    int          n;
    int          fail_count;
    int          n_tests;
    asq_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_unit_trig(pulse_unit_trig),
        .timer_unit_trig(timer_unit_trig),
        .external_trigger_pin_n(external_trigger_pin_n),
        .dma_result_read(dma_result_read), .comparator_hi(comparator_hi),
        .sample_channel(sample_channel),
        .conversion_clock(conversion_clock),
        .conversion_end_irq(conversion_end_irq));
    asq_comp_model u_cmp (.sample_channel(sample_channel), .flip(flip),
        .comparator_hi(comparator_hi));
    // clock at 10 MHz
    always #50 pclk = ~pclk;
    // ========================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk
    // one transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] v);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic rres(input int ch);
        rd(`ASQ_RES_OFS + 12'(4 * ch));
    endtask : rres
    function automatic logic [31:0] res(input int ch);
        return (ch[0] ^ flip) ? 32'h3FF : 32'h0;
    endfunction : res
    // bounded wait; n is cycles since the launching edge
    task automatic wait_irq;
        n = 0;
        while (conversion_end_irq !== 1'b1 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        chk(n < 2000, 1'b1, "no end irq");
    endtask : wait_irq
    task automatic fire(input int s);
        @(posedge pclk);
        pulse_unit_trig <= (s == 0);
        timer_unit_trig <= (s == 1);
        external_trigger_pin_n <= (s != 2);
        repeat (2) @(posedge pclk);
        pulse_unit_trig <= 1'b0;
        timer_unit_trig <= 1'b0;
        external_trigger_pin_n <= 1'b1;
    endtask : fire
    // ========================================================
    // scenarios
    task automatic t_regs;
        rd(CTL);
        chk(d, 32'h0, "ctl reset");
        rd(CSR);
        chk(d, 32'h0, "csr reset");
        wr(CTL, 32'hA5);
        rd(CTL);
        chk(d, 32'hA5, "ctl rw");
        rd(12'h100);
        chk(e, 1'b1, "no error");
        chk(d, 32'h0, "unmapped data");
        wr(CTL, 32'h0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_single;
        wr(CTL, 32'h10);
        wr(CSR, 32'h61);
        wait_irq;
        chk(n >= 47 && n <= 53, 1'b1, "single time");
        wr(CSR, 32'h41);
        rd(CSR);
        chk(d, 32'hC1, "flag done");
        rres(1);
        chk(d, res(1), "single result");
        wr(CSR, 32'h41);
        repeat (3) @(posedge pclk);
        chk(conversion_end_irq, 1'b0, "irq held");
        rd(CSR);
        chk(d, 32'h41, "flag kept");
        $display("t_single done");
    endtask : t_single
    task automatic t_abort;
        wr(CTL, 32'h0C);
        wr(CSR, 32'h62);
        repeat (60) @(posedge pclk);
        rd(CSR);
        chk(d, 32'h62, "start low early");
        wr(CSR, 32'h42);
        repeat (400) @(posedge pclk);
        rd(CSR);
        chk(d, 32'h42, "abort failed");
        chk(conversion_end_irq, 1'b0, "irq on abort");
        $display("t_abort done");
    endtask : t_abort
    task automatic t_trig;
        wr(CSR, 32'h0);
        for (int c = 0; c < 8; c++)
        begin
            wr(CTL, {24'h0, c[2], c[1], 5'h0, c[0]});
            for (int s = 0; s < 3; s++)
            begin
                fire(s);
                repeat (8) @(posedge pclk);
                rd(CSR);
                if (c == 2 * s + 2)
                    chk(d[5], 1'b1, "on");
                else
                    chk(d[5], 1'b0, "off");
                if (d[5])
                    wr(CSR, 32'h0);
            end
        end
        $display("t_trig done");
    endtask : t_trig
    task automatic t_scan1;
        flip <= 1'b1;
        wr(CTL, 32'h22);
        wr(CSR, 32'h66);
        wait_irq;
        chk(n >= 128 && n <= 136, 1'b1, "pass time");
        rd(CSR);
        chk(d, 32'hC6, "one pass end");
        for (int ch = 4; ch < 7; ch++)
        begin
            rres(ch);
            chk(d, res(ch), "scan result");
        end
        wr(CSR, 32'h06);
        $display("t_scan1 done");
    endtask : t_scan1
    task automatic t_scan2;
        flip <= 1'b0;
        wr(CTL, 32'h30);
        wr(CSR, 32'h63);
        wait_irq;
        rd(CSR);
        chk(d, 32'hE3, "start cleared");
        for (int ch = 0; ch < 4; ch++)
        begin
            rres(ch);
            chk(d, res(ch), "pass one");
        end
        flip <= 1'b1;
        wr(CSR, 32'h63);
        repeat (3) @(posedge pclk);
        wait_irq;
        chk(n < 200, 1'b1, "no restart");
        dma_result_read <= 1'b1;
        @(posedge pclk);
        dma_result_read <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(CSR);
        chk(d, 32'h63, "dma clear");
        wait_irq;
        for (int ch = 0; ch < 4; ch++)
        begin
            rres(ch);
            chk(d, res(ch), "pass three");
        end
        wr(CSR, 32'h03);
        repeat (400) @(posedge pclk);
        rd(CSR);
        chk(d, 32'h83, "scan stop");
        $display("t_scan2 done");
    endtask : t_scan2
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // ========================================================
    // main sequence; inputs idle at time zero
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pulse_unit_trig = 1'b0;
        timer_unit_trig = 1'b0;
        external_trigger_pin_n = 1'b1;
        dma_result_read = 1'b0;
        flip = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_single;
        t_abort;
        t_trig;
        t_scan1;
        t_scan2;
        wrap_up;
    end
    // watchdog, far beyond the run's length
    initial
    begin
        repeat (40000) @(posedge pclk);
        fail_count++;
        wrap_up;
    end
endmodule : adc_sequencer_control_bench
bind asq_ctrl asq_ctrl_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_result_read(dma_result_read),
    .sample_channel(sample_channel), .conversion_clock(conversion_clock),
    .conversion_end_irq(conversion_end_irq));
